// ==== src/dram_pd_ctrl.sv ====
// Controller end: link clock, command issue, power-down entry and exit
`timescale 1ns/1ns
`default_nettype none
`include "pd_link_defines.svh"
module dram_pd_ctrl #(
  parameter int PD_MIN_NCK = `MIN_POWER_DOWN_NCK,
  parameter int CKE_NCK = `CLK_EN_MIN_PULSE_NCK,
  parameter int XP_NCK = `PD_EXIT_LATENCY_NCK,
  parameter int BUSY_NCK = `BURST_BUSY_NCK,
  parameter int PD_LIMIT_NCK = `PD_REFRESH_MULT * `AVG_REFRESH_INTERVAL_NS / `CK_PERIOD_NS
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Link
  pd_link_if.ctrl link
);
  import pd_link_pkg::*;

  localparam int XP_PAR_NS_NCK = (`XP_PAR_NS + `CK_PERIOD_NS - 1) / `CK_PERIOD_NS;
  localparam int XP_PAR_BASE = (XP_PAR_NS_NCK > `XP_PAR_MIN_NCK) ? XP_PAR_NS_NCK : `XP_PAR_MIN_NCK;
  localparam int XP_HOLD = (XP_NCK > CKE_NCK) ? XP_NCK : CKE_NCK;
  localparam int XPP_HOLD = (XP_PAR_BASE > CKE_NCK) ? XP_PAR_BASE : CKE_NCK;

  typedef struct packed {
    ctl_state_t st;
    logic ck;
    logic cke;
    link_cmd_t cmd;
    link_addr_t addr;
    logic rstn;
    logic odt_oe;
    logic [15:0] cnt;
    logic [15:0] ref_cnt;
    logic [5:0] busy;
    logic pd_req;
    logic dram_rst;
    logic pend;
    link_cmd_t pcode;
    link_addr_t paddr;
    logic limit;
    logic par_en;
    logic [2:0] pl;
    logic odt_off;
    logic [31:0] rdata;
  } ctl_regs_t;

  ctl_regs_t s_q;
  ctl_regs_t s_d;
  logic tick;
  logic limit_set;

  // Link signals move while the link clock falls, so the DRAM sees them settled
  assign tick = s_q.ck;

  always_comb
  begin
    s_d = s_q;
    s_d.ck = ~s_q.ck;
    limit_set = 1'b0;
    if (tick)
    begin
      s_d.cmd = CMD_DES;
      s_d.rstn = !s_q.dram_rst;
      if (s_q.busy != 6'h00)
      begin
        s_d.busy = s_q.busy - 6'h01;
      end
      if (s_q.cnt != 16'h0000)
      begin
        s_d.cnt = s_q.cnt - 16'h0001;
      end
      if (s_q.dram_rst)
      begin
        s_d.st = CTL_RUN;
        s_d.cke = 1'b1;
        s_d.odt_oe = 1'b1;
        s_d.cnt = 16'h0000;
        s_d.busy = 6'h00;
        s_d.par_en = 1'b0;
        s_d.pl = 3'h0;
        s_d.odt_off = 1'b0;
      end
      else
      begin
        unique case (s_q.st)
          CTL_RUN:
          begin
            s_d.cke = 1'b1;
            s_d.odt_oe = 1'b1;
            if (s_q.cnt != 16'h0000)
            begin
              s_d.cmd = CMD_DES;
            end
            else if (s_q.pend)
            begin
              s_d.pend = 1'b0;
              s_d.cmd = s_q.pcode;
              s_d.addr = s_q.paddr;
              if (s_q.pcode inside {CMD_RD, CMD_WR, CMD_MRS, CMD_ZQ})
              begin
                s_d.busy = 6'(BUSY_NCK);
              end
              if (s_q.pcode == CMD_MRS)
              begin
                s_d.par_en = s_q.paddr[`MR_PAR_EN_BIT];
                s_d.pl = s_q.paddr[`MR_PL_MSB:`MR_PL_LSB];
                s_d.odt_off = s_q.paddr[`MR_ODT_BUF_OFF_BIT];
              end
            end
            else if (s_q.pd_req && s_q.busy == 6'h00)
            begin
              s_d.cke = 1'b0;
              s_d.st = CTL_PD;
              s_d.cnt = 16'(PD_MIN_NCK - 1);
              s_d.ref_cnt = 16'(PD_LIMIT_NCK - 1);
            end
          end
          CTL_PD:
          begin
            s_d.cmd = CMD_DES;
            // enable held low, termination per setting
            s_d.cke = 1'b0;
            s_d.odt_oe = !s_q.odt_off;
            if (s_q.ref_cnt != 16'h0000)
            begin
              s_d.ref_cnt = s_q.ref_cnt - 16'h0001;
            end
            if (s_q.cnt == 16'h0000 && (!s_q.pd_req || s_q.ref_cnt == 16'h0000))
            begin
              // exit with deselect and held pulse
              s_d.cke = 1'b1;
              s_d.odt_oe = 1'b1;
              s_d.st = CTL_RUN;
              limit_set = (s_q.ref_cnt == 16'h0000);
              s_d.cnt = s_q.par_en ? 16'(XPP_HOLD) + {13'h0000, s_q.pl} : 16'(XP_HOLD);
            end
          end
        endcase
      end
    end
    s_d.rdata = 32'h00000000;
    if (WR)
    begin
      unique case (ADDR)
        `REG_CTRL:
        begin
          s_d.pd_req = WDATA[`CTRL_PD_REQ_BIT];
          s_d.dram_rst = WDATA[`CTRL_DRAM_RST_BIT];
        end
        `REG_CMD:
        begin
          if (!s_q.pend)
          begin
            s_d.pend = 1'b1;
            s_d.pcode = link_cmd_t'(WDATA[`CMD_CODE_LSB +: 3]);
            s_d.paddr = WDATA[10:0];
          end
        end
        `REG_STATUS:
        begin
          if (WDATA[`ST_LIMIT_BIT])
          begin
            s_d.limit = 1'b0;
          end
        end
        default:
        begin
          s_d.limit = s_d.limit;
        end
      endcase
    end
    // Hardware set wins over a clear in the same cycle
    if (limit_set)
    begin
      s_d.limit = 1'b1;
    end
    if (RD)
    begin
      unique case (ADDR)
        `REG_CTRL: s_d.rdata = {30'h00000000, s_q.dram_rst, s_q.pd_req};
        `REG_CMD: s_d.rdata = {17'h00000, s_q.pcode, 1'b0, s_q.paddr};
        `REG_STATUS: s_d.rdata = {28'h0000000, (s_q.cnt != 16'h0000) || (s_q.busy != 6'h00), s_q.limit,
                                  s_q.pend, s_q.st == CTL_PD};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign RDATA = s_q.rdata;
  assign link.ck = s_q.ck;
  assign link.cke = s_q.cke;
  assign link.cmd = s_q.cmd;
  assign link.addr = s_q.addr;
  assign link.reset_n = s_q.rstn;
  assign link.odt = 1'b0;
  assign link.odt_oe = s_q.odt_oe;
endmodule // dram_pd_ctrl
`default_nettype wire

// ==== src/dram_pd_device.sv ====
// DRAM end: power-down entry, classification, receiver gating, exit latency
`timescale 1ns/1ns
`default_nettype none
`include "pd_link_defines.svh"
module dram_pd_device #(
  parameter int CK_PERIOD_NS = `CK_PERIOD_NS,
  parameter int XP_NCK = `PD_EXIT_LATENCY_NCK,
  parameter int CPDED_NCK = `COMMAND_DISABLE_DELAY_NCK,
  parameter int BANK_OP_NCK = `BANK_OP_NCK,
  parameter int REFRESH_OP_NCK = `REFRESH_OP_NCK
) (
  // Link
  pd_link_if.dram link,
  // Accepted commands
  output logic CMD_STB,
  output pd_link_pkg::link_cmd_t CMD_CODE,
  output pd_link_pkg::link_addr_t CMD_ADDR,
  output logic CMD_READY,
  // Power state
  output logic PD_ACTIVE,
  output logic PD_PRECHARGE,
  output logic DLL_EN,
  // Buffers and termination
  output logic CA_RX_EN,
  output logic IO_BUF_EN,
  output logic ODT_BUF_EN,
  output logic NOM_TERM_EN,
  output logic PARK_TERM_EN
);
  import pd_link_pkg::*;

  // ----------------------------------------
  // Derived counts
  // ----------------------------------------
  localparam int XP_PAR_NS_NCK = (`XP_PAR_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
  localparam int XP_PAR_BASE = (XP_PAR_NS_NCK > `XP_PAR_MIN_NCK) ? XP_PAR_NS_NCK : `XP_PAR_MIN_NCK;
  localparam logic [7:0] XP_LOAD = 8'(XP_NCK - 1);
  localparam logic [7:0] XP_PAR_LOAD = 8'(XP_PAR_BASE - 1);
  localparam logic [3:0] CPDED_LOAD = 4'(CPDED_NCK);
  localparam logic [5:0] BANK_OP_LOAD = 6'(BANK_OP_NCK);
  localparam logic [5:0] REF_OP_LOAD = 6'(REFRESH_OP_NCK);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    dev_state_t st;
    logic dll_on;
    logic [5:0] busy;
    logic [3:0] cpded;
    logic [7:0] xp;
    logic [3:0] banks;
    logic [2:0] pl;
    logic odt_off;
    logic [2:0] park;
    logic par_en;
    logic nom_en;
    logic stb;
    link_cmd_t code;
    link_addr_t addr;
  } dev_regs_t;

  dev_regs_t s_q;
  dev_regs_t s_d;
  logic in_pd;
  logic [7:0] exit_load;

  assign in_pd = (s_q.st != DEV_IDLE);
  assign exit_load = s_q.par_en ? (XP_PAR_LOAD + {5'h00, s_q.pl}) : XP_LOAD;

  always_comb
  begin
    s_d = s_q;
    s_d.stb = 1'b0;
    s_d.dll_on = 1'b1;
    if (s_q.busy != 6'h00)
    begin
      s_d.busy = s_q.busy - 6'h01;
    end
    if (in_pd && s_q.cpded != 4'h0)
    begin
      s_d.cpded = s_q.cpded - 4'h1;
    end
    unique case (s_q.st)
      DEV_IDLE:
      begin
        if (s_q.xp != 8'h00)
        begin
          s_d.xp = s_q.xp - 8'h01;
        end
        if (!link.cke)
        begin
          s_d.st = DEV_PD_WAIT;
          s_d.cpded = CPDED_LOAD;
        end
        else if (s_q.xp == 8'h00 && link.cmd != CMD_DES)
        begin
          s_d.stb = 1'b1;
          s_d.code = link.cmd;
          s_d.addr = link.addr;
          unique case (link.cmd)
            CMD_ACT:
            begin
              s_d.banks[link.addr[1:0]] = 1'b1;
              s_d.busy = BANK_OP_LOAD;
            end
            CMD_PRE:
            begin
              if (link.addr[`PRE_ALL_BIT])
              begin
                s_d.banks = 4'h0;
              end
              else
              begin
                s_d.banks[link.addr[1:0]] = 1'b0;
              end
              s_d.busy = BANK_OP_LOAD;
            end
            CMD_REF:
            begin
              s_d.busy = REF_OP_LOAD;
            end
            CMD_MRS:
            begin
              s_d.pl = link.addr[`MR_PL_MSB:`MR_PL_LSB];
              s_d.odt_off = link.addr[`MR_ODT_BUF_OFF_BIT];
              s_d.park = link.addr[`MR_PARK_MSB:`MR_PARK_LSB];
              s_d.par_en = link.addr[`MR_PAR_EN_BIT];
              s_d.nom_en = link.addr[`MR_NOM_EN_BIT];
            end
            default:
            begin
              s_d.busy = s_q.busy;
            end
          endcase
        end
      end
      DEV_PD_WAIT:
      begin
        if (link.cke)
        begin
          s_d.st = DEV_IDLE;
          s_d.xp = exit_load;
        end
        else if (s_q.busy == 6'h00)
        begin
          s_d.st = (s_q.banks != 4'h0) ? DEV_PD_ACT : DEV_PD_PRE;
        end
      end
      DEV_PD_ACT, DEV_PD_PRE:
      begin
        if (link.cke)
        begin
          s_d.st = DEV_IDLE;
          s_d.xp = exit_load;
        end
      end
    endcase
  end

  // reset pin leaves power-down at once
  always_ff @(posedge link.ck or negedge link.reset_n)
  begin
    if (!link.reset_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign CMD_STB = s_q.stb;
  assign CMD_CODE = s_q.code;
  assign CMD_ADDR = s_q.addr;
  assign CMD_READY = (s_q.st == DEV_IDLE) && (s_q.xp == 8'h00);
  assign PD_ACTIVE = (s_q.st == DEV_PD_ACT);
  assign PD_PRECHARGE = (s_q.st == DEV_PD_PRE);
  assign DLL_EN = s_q.dll_on;
  assign CA_RX_EN = !(in_pd && s_q.cpded == 4'h0);
  assign IO_BUF_EN = !in_pd;
  assign ODT_BUF_EN = !in_pd || !s_q.odt_off;
  assign NOM_TERM_EN = s_q.nom_en && ODT_BUF_EN && link.odt && link.odt_oe;
  assign PARK_TERM_EN = (s_q.park != 3'h0);
endmodule // dram_pd_device
`default_nettype wire

// ==== src/pd_link_defines.svh ====
// Constants shared by both ends of the power-down link
`ifndef PD_LINK_DEFINES_SVH
`define PD_LINK_DEFINES_SVH
// Behaviour
// - Entry when clock-enable sampled low, with deselect
// - Controller keeps clock-enable high during busy operations
// - Activate, precharge, refresh finish before low-power state
// - All banks closed precharge, else active
// - Entry disables buffers except clock, enable, reset
// - Buffer-disable bit decides termination input buffer state
// - Park termination stays on when enabled
// - Deselects during command-disable delay, then receivers off
// - DLL stays on, fast exit always
// - Controller holds enable low, reset high, termination valid
// - Reset during power-down forces reset state
// - Power-down lasts at most nine refresh intervals
// - Exit on enable high with deselect, pulse held
// - Termination input driven at exit if nominal enabled
// - No command before exit latency elapses
// - Minimum power-down time before exit
// - Parity exit latency max(4 cycles, 6 ns) plus latency
// - Controller should lock DLL before entry

// ----------------------------------------
// Link timing
// ----------------------------------------
`define MCLK_PERIOD_NS 10
`define CK_DIV 2
`define CK_PERIOD_NS (`MCLK_PERIOD_NS * `CK_DIV)
`define PD_EXIT_LATENCY_NCK 4
`define CLK_EN_MIN_PULSE_NCK 4
`define MIN_POWER_DOWN_NCK `CLK_EN_MIN_PULSE_NCK
`define COMMAND_DISABLE_DELAY_NCK 4
`define XP_PAR_MIN_NCK 4
`define XP_PAR_NS 6
`define BANK_OP_NCK 6
`define REFRESH_OP_NCK 20
`define BURST_BUSY_NCK 8
`define AVG_REFRESH_INTERVAL_NS 7800
`define PD_REFRESH_MULT 9

// ----------------------------------------
// Mode register fields (command address bits)
// ----------------------------------------
`define MR_PL_LSB 0
`define MR_PL_MSB 2
`define MR_ODT_BUF_OFF_BIT 5
`define MR_PARK_LSB 6
`define MR_PARK_MSB 8
`define MR_PAR_EN_BIT 9
`define MR_NOM_EN_BIT 10
`define PRE_ALL_BIT 10

// ----------------------------------------
// Controller registers
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_CMD 4'h1
`define REG_STATUS 4'h2
`define CTRL_PD_REQ_BIT 0
`define CTRL_DRAM_RST_BIT 1
`define CMD_CODE_LSB 12
`define ST_IN_PD_BIT 0
`define ST_PEND_BIT 1
`define ST_LIMIT_BIT 2
`define ST_WAIT_BIT 3
`endif

// ==== src/pd_link_if.sv ====
// Link between memory controller and DRAM power-down logic
`timescale 1ns/1ns
`default_nettype none
interface pd_link_if;
  import pd_link_pkg::*;
  logic ck;
  logic cke;
  link_cmd_t cmd;
  link_addr_t addr;
  logic reset_n;
  logic odt;
  logic odt_oe;

  modport ctrl (output ck, output cke, output cmd, output addr, output reset_n, output odt, output odt_oe);
  modport dram (input ck, input cke, input cmd, input addr, input reset_n, input odt, input odt_oe);
endinterface
`default_nettype wire

// ==== src/pd_link_pkg.sv ====
// Types shared by both ends of the power-down link
package pd_link_pkg;
  typedef enum logic [2:0]
  {
    CMD_DES = 3'h0,
    CMD_ACT = 3'h1,
    CMD_PRE = 3'h2,
    CMD_REF = 3'h3,
    CMD_MRS = 3'h4,
    CMD_RD = 3'h5,
    CMD_WR = 3'h6,
    CMD_ZQ = 3'h7
  } link_cmd_t;

  typedef enum logic [1:0]
  {
    DEV_IDLE = 2'h0,
    DEV_PD_WAIT = 2'h1,
    DEV_PD_ACT = 2'h2,
    DEV_PD_PRE = 2'h3
  } dev_state_t;

  typedef enum logic [0:0]
  {
    CTL_RUN = 1'h0,
    CTL_PD = 1'h1
  } ctl_state_t;

  typedef logic [10:0] link_addr_t;
endpackage

// ==== tb/dram_power_down_control_bench.sv ====
// Bench joining controller and device ends of the power-down link
`timescale 1ns/1ns
`default_nettype none
`include "pd_link_defines.svh"
module dram_power_down_control_bench;
  import pd_link_pkg::*;
  typedef struct {logic [10:0] mr; link_cmd_t code; logic [10:0] a; logic act; logic odtb; logic park; int xp;} row_t;
  logic mclk, rst, wr_stb, rd_stb;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, st;
  logic cmd_stb, cmd_ready, pd_active, pd_precharge, dll_en, ca_rx_en, io_buf_en, odt_buf_en, nom_term_en;
  logic park_term_en;
  link_cmd_t cmd_code;
  link_addr_t cmd_addr;
  int n_mismatch, checked;
  // Mode value, command, address, then expected class, odt buffer, park, exit latency
  row_t rows[5] = '{'{11'h000, CMD_ACT, 11'h000, 1'b1, 1'b1, 1'b0, 4}, '{11'h020, CMD_PRE, 11'h400, 1'b0, 1'b0, 1'b0, 4},
    '{11'h040, CMD_REF, 11'h000, 1'b0, 1'b1, 1'b1, 4}, '{11'h223, CMD_ACT, 11'h001, 1'b1, 1'b0, 1'b0, 7},
    '{11'h1E0, CMD_PRE, 11'h400, 1'b0, 1'b0, 1'b1, 4}};

  pd_link_if link ();
  // Short limit keeps the forced-exit case brief
  dram_pd_ctrl #(.PD_LIMIT_NCK(40)) u_dram_pd_ctrl (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr_stb), .RD(rd_stb), .RDATA(rdata), .link(link.ctrl));
  dram_pd_device u_dram_pd_device (.link(link.dram), .CMD_STB(cmd_stb), .CMD_CODE(cmd_code), .CMD_ADDR(cmd_addr),
    .CMD_READY(cmd_ready), .PD_ACTIVE(pd_active), .PD_PRECHARGE(pd_precharge), .DLL_EN(dll_en), .CA_RX_EN(ca_rx_en),
    .IO_BUF_EN(io_buf_en), .ODT_BUF_EN(odt_buf_en), .NOM_TERM_EN(nom_term_en), .PARK_TERM_EN(park_term_en));
  pd_link_asserts u_pd_link_asserts (.ck(link.ck), .cke(link.cke), .cmd(link.cmd), .reset_n(link.reset_n),
    .CMD_STB(cmd_stb), .CMD_READY(cmd_ready), .PD_ACTIVE(pd_active), .PD_PRECHARGE(pd_precharge), .DLL_EN(dll_en),
    .CA_RX_EN(ca_rx_en), .IO_BUF_EN(io_buf_en));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic guard(input int n);
    if (n >= 60)
    begin
      chk(1'b0, "wait timed out");
      end_sim();
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge link.ck);
    #1;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Queue a command, then poll until sent and no busy count runs
  task automatic issue(input link_cmd_t c, input logic [10:0] a);
    int i;
    reg_wr(`REG_CMD, {17'h00000, c, 1'b0, a});
    for (i = 0; i < 60; i++)
    begin
      reg_rd(`REG_STATUS, st);
      if (st[`ST_PEND_BIT] === 1'b0 && st[`ST_WAIT_BIT] === 1'b0)
        return;
    end
    guard(i);
  endtask

  // Counts link clocks from the enable-high edge to ready, less one
  task automatic exit_pd(output int n);
    reg_wr(`REG_CTRL, 32'h00000000);
    for (n = 0; n < 60 && link.cke !== 1'b1; n++)
      ticks(1);
    guard(n);
    for (n = 0; n < 60 && cmd_ready !== 1'b1; n++)
      ticks(1);
    guard(n);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    int n;
    rst = 1'b1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 4'h0;
    wdata = 32'h00000000;
    n_mismatch = 0;
    checked = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    ticks(4);
    foreach (rows[i])
    begin
      issue(CMD_MRS, rows[i].mr);
      issue(rows[i].code, rows[i].a);
      chk(cmd_code === rows[i].code && cmd_addr === rows[i].a, "command lost");
      reg_wr(`REG_CTRL, 32'h00000001);
      ticks(3);
      chk(link.cke === 1'b0 && link.cmd === CMD_DES && io_buf_en === 1'b0, "entry");
      chk(rows[i].code !== CMD_REF || pd_precharge === 1'b0, "low power before refresh done");
      ticks(30);
      chk(pd_active === rows[i].act && pd_precharge === !rows[i].act, "power-down kind");
      chk(ca_rx_en === 1'b0 && dll_en === 1'b1, "receivers or dll");
      chk(odt_buf_en === rows[i].odtb && link.odt_oe === rows[i].odtb, "odt buffer");
      chk(park_term_en === rows[i].park && nom_term_en === 1'b0, "park termination");
      exit_pd(n);
      chk(n + 1 === rows[i].xp && io_buf_en === 1'b1, "exit latency");
      chk(link.odt_oe === 1'b1, "termination input left floating");
    end
    reg_rd(4'hF, st);
    chk(st === 32'h00000000, "unmapped read");
    // Entry must wait for the busy count of a mode write
    reg_wr(`REG_CMD, {17'h00000, CMD_MRS, 1'b0, 11'h000});
    reg_wr(`REG_CTRL, 32'h00000001);
    ticks(4);
    chk(link.cke === 1'b1, "entry while busy");
    // Power-down held past the limit must be cut short
    reg_wr(`REG_CTRL, 32'h00000001);
    for (n = 0; n < 60 && link.cke !== 1'b0; n++)
      ticks(1);
    guard(n);
    for (n = 0; n < 60 && link.cke !== 1'b1; n++)
      ticks(1);
    guard(n);
    reg_rd(`REG_STATUS, st);
    chk(n > 36 && n <= 41 && st[`ST_LIMIT_BIT] === 1'b1, "power-down limit");
    reg_wr(`REG_STATUS, 32'h00000004);
    exit_pd(n);
    // Device reset while in power-down
    reg_wr(`REG_CTRL, 32'h00000001);
    ticks(20);
    chk(pd_precharge === 1'b1, "not in power-down");
    reg_wr(`REG_CTRL, 32'h00000003);
    ticks(3);
    chk(link.reset_n === 1'b0 && pd_active === 1'b0 && pd_precharge === 1'b0, "reset in power-down");
    reg_wr(`REG_CTRL, 32'h00000000);
    // Ready also stands during reset, so wait for the reset pin to rise first
    for (n = 0; n < 60 && (link.reset_n !== 1'b1 || cmd_ready !== 1'b1); n++)
      ticks(1);
    guard(n);
    chk(dll_en === 1'b1 && link.reset_n === 1'b1 && cmd_ready === 1'b1, "after reset");
    end_sim();
  end
endmodule // dram_power_down_control_bench
`default_nettype wire

// ==== tb/pd_link_asserts.sv ====
// Checker of the power-down link, watching the wire and the device state
`timescale 1ns/1ns
`default_nettype none
module pd_link_asserts
  import pd_link_pkg::*;
(
  // Link
  input wire logic ck,
  input wire logic cke,
  input wire link_cmd_t cmd,
  input wire logic reset_n,
  // Device state
  input wire logic CMD_STB,
  input wire logic CMD_READY,
  input wire logic PD_ACTIVE,
  input wire logic PD_PRECHARGE,
  input wire logic DLL_EN,
  input wire logic CA_RX_EN,
  input wire logic IO_BUF_EN
);
  // ----------------------------------------
  // Link clock domain, device reset
  // ----------------------------------------
  default clocking cb @(posedge ck); endclocking
  default disable iff (!reset_n);

  property p_entry_des; $fell(cke) |-> cmd == CMD_DES; endproperty
  a_entry_des: assert property (p_entry_des) else $error("entry without deselect");
  property p_cpded_des; $fell(cke) |-> (cmd == CMD_DES) [*4]; endproperty
  a_cpded_des: assert property (p_cpded_des) else $error("command during disable delay");
  property p_rx_on; $fell(cke) |=> CA_RX_EN; endproperty
  a_rx_on: assert property (p_rx_on) else $error("receivers off too early");
  // Receivers must be off once the delay has run out
  property p_rx_off; $fell(cke) ##1 (!cke) [*5] |-> !CA_RX_EN; endproperty
  a_rx_off: assert property (p_rx_off) else $error("receivers still on");
  property p_bufs_off; $fell(cke) |=> !IO_BUF_EN; endproperty
  a_bufs_off: assert property (p_bufs_off) else $error("buffers on in power-down");
  property p_min_pd; $fell(cke) |-> (!cke) [*4]; endproperty
  a_min_pd: assert property (p_min_pd) else $error("power-down too short");
  property p_exit_des; $rose(cke) |-> cmd == CMD_DES; endproperty
  a_exit_des: assert property (p_exit_des) else $error("exit without deselect");
  property p_cke_hold; $rose(cke) |-> cke [*4]; endproperty
  a_cke_hold: assert property (p_cke_hold) else $error("enable pulse too short");
  // Asserting the device reset also raises enable; not an exit
  property p_xp_des; $rose(cke) && $past(reset_n) |-> (cmd == CMD_DES) [*4]; endproperty
  a_xp_des: assert property (p_xp_des) else $error("command inside exit latency");
  property p_xp_ready; $rose(cke) && $past(reset_n) |=> (!CMD_READY) [*3] ##[1:12] CMD_READY; endproperty
  a_xp_ready: assert property (p_xp_ready) else $error("exit latency wrong");
  property p_stb_ready; CMD_STB |-> $past(CMD_READY); endproperty
  a_stb_ready: assert property (p_stb_ready) else $error("command taken while not ready");
  property p_dll; PD_ACTIVE || PD_PRECHARGE |-> DLL_EN && !IO_BUF_EN; endproperty
  a_dll: assert property (p_dll) else $error("dll off in power-down");
  // A power-down class may only follow a cycle that sampled enable low
  property p_class; (PD_ACTIVE || PD_PRECHARGE) |-> !$past(cke) && !(PD_ACTIVE && PD_PRECHARGE); endproperty
  a_class: assert property (p_class) else $error("both power-down kinds");
endmodule // pd_link_asserts
`default_nettype wire
